/* hw/sdpp_pkg.sv */
// shared constants, types and decoders of the dram pin port
package sdpp_pkg;

  localparam int ADDR_W     = 20;
  localparam int BANK_W     = 3;
  localparam int DATA_W     = 18;
  localparam int HALF_W     = 9;
  localparam int LANES      = 2;
  localparam int MAX_BL     = 8;
  localparam int WBUF_W     = MAX_BL * DATA_W;
  localparam int BLC_W      = 2;
  localparam int BLC_LSB    = 0;
  localparam int CNT_W      = 4;
  localparam int REF_CNT_W  = 8;
  localparam int COL_W_DEF  = 4;
  localparam int RD_LAT_DEF = 2;
  localparam int PH_W       = 2;

  // burst length codes in the configuration word
  localparam logic [BLC_W-1:0] BLC_2   = 2'h0;
  localparam logic [BLC_W-1:0] BLC_4   = 2'h1;
  localparam logic [BLC_W-1:0] BLC_8   = 2'h2;
  localparam logic [BLC_W-1:0] BLC_RST = BLC_2;

  // word pairs per burst
  localparam logic [CNT_W-1:0] PAIRS_BL2 = 4'h1;
  localparam logic [CNT_W-1:0] PAIRS_BL4 = 4'h2;
  localparam logic [CNT_W-1:0] PAIRS_BL8 = 4'h4;

  // controller divider phases, one link clock period
  localparam logic [PH_W-1:0] PH_A = 2'h0;
  localparam logic [PH_W-1:0] PH_B = 2'h1;
  localparam logic [PH_W-1:0] PH_C = 2'h2;
  localparam logic [PH_W-1:0] PH_D = 2'h3;

  typedef enum logic [1:0] {
    CMD_READ  = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_REF   = 2'b10,
    CMD_CFG   = 2'b11
  } sdpp_cmd_e;

  // command pin levels {wr_cmd_n, ref_cmd_n}
  localparam logic [1:0] PINS_READ  = 2'h3;
  localparam logic [1:0] PINS_WRITE = 2'h1;
  localparam logic [1:0] PINS_REF   = 2'h2;
  localparam logic [1:0] PINS_CFG   = 2'h0;
  localparam logic [1:0] PINS_NOP   = 2'h3;

  function automatic sdpp_cmd_e sdpp_decode(input logic [1:0] lv);
    case (lv)
      PINS_WRITE: return CMD_WRITE;
      PINS_REF:   return CMD_REF;
      PINS_CFG:   return CMD_CFG;
      default:    return CMD_READ;
    endcase
  endfunction

  function automatic logic [1:0] sdpp_encode(input sdpp_cmd_e c);
    case (c)
      CMD_WRITE: return PINS_WRITE;
      CMD_REF:   return PINS_REF;
      CMD_CFG:   return PINS_CFG;
      default:   return PINS_READ;
    endcase
  endfunction

  // reserved code falls back to the shortest burst
  function automatic logic [CNT_W-1:0] sdpp_pairs(input logic [BLC_W-1:0] code);
    case (code)
      BLC_4:   return PAIRS_BL4;
      BLC_8:   return PAIRS_BL8;
      default: return PAIRS_BL2;
    endcase
  endfunction

endpackage

/* hw/sdpp_if.sv */
// pin bundle between the dram device end and its controller
`timescale 1ns/1ps
interface sdpp_if;
  import sdpp_pkg::*;

  logic [ADDR_W-1:0] addr_bus;
  logic [BANK_W-1:0] bank_sel;
  logic              main_clk_true;
  logic              main_clk_comp;
  logic              sel_n;
  logic              wr_cmd_n;
  logic              ref_cmd_n;
  logic [DATA_W-1:0] write_data_bus;
  logic              wr_strobe_true;
  logic              wr_strobe_comp;
  logic              write_mask;
  logic [DATA_W-1:0] read_data_bus;
  logic [LANES-1:0]  rd_strobe_true;
  logic [LANES-1:0]  rd_strobe_comp;
  logic              read_valid;

  modport dev (
    input  addr_bus, bank_sel, main_clk_true, main_clk_comp, sel_n, wr_cmd_n,
    input  ref_cmd_n, write_data_bus, wr_strobe_true, wr_strobe_comp, write_mask,
    output read_data_bus, rd_strobe_true, rd_strobe_comp, read_valid
  );

  modport ctl (
    output addr_bus, bank_sel, main_clk_true, main_clk_comp, sel_n, wr_cmd_n,
    output ref_cmd_n, write_data_bus, wr_strobe_true, wr_strobe_comp, write_mask,
    input  read_data_bus, rd_strobe_true, rd_strobe_comp, read_valid
  );

endinterface

/* hw/sdpp_ctl.sv */
// controller end of the dram pin port: link clocks, commands, bursts
`timescale 1ns/1ps
module sdpp_ctl (
  sdpp_if.ctl                              pins,
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire sdpp_pkg::sdpp_cmd_e         req_cmd,
  input  wire logic [sdpp_pkg::BANK_W-1:0] req_bank,
  input  wire logic [sdpp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [sdpp_pkg::WBUF_W-1:0] req_wdata,
  input  wire logic [sdpp_pkg::MAX_BL-1:0] req_wmask,
  output logic                             rsp_valid,
  output logic [2*sdpp_pkg::DATA_W-1:0]    rsp_data
);
  import sdpp_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CMD   = 2'b01,
    ST_WDATA = 2'b10
  } sdpp_st_e;

  logic [PH_W-1:0]   phase_reg;
  logic              ck_reg;
  logic              dk_reg;
  sdpp_st_e          state_reg;
  logic              is_wr_reg;
  logic [BLC_W-1:0]  blc_reg;
  logic [CNT_W-1:0]  words_left_reg;
  logic [WBUF_W-1:0] wbuf_reg;
  logic [MAX_BL-1:0] mbuf_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              wmask_reg;
  logic              sel_n_reg;
  logic [1:0]        cmd_pins_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [BANK_W-1:0] bank_reg;
  logic [DATA_W-1:0] rd_low_reg;
  logic              rd_vld_reg;
  logic              boundary;
  logic              mid;
  logic              take;
  logic              launch;

  assign boundary  = phase_reg == PH_D;
  assign mid       = phase_reg == PH_B;
  assign req_ready = state_reg == ST_IDLE && boundary;
  assign take      = req_ready && req_valid;
  assign launch    = (state_reg == ST_CMD && boundary && is_wr_reg)
                  || (state_reg == ST_WDATA && mid)
                  || (state_reg == ST_WDATA && boundary && words_left_reg != '0);

  // dk leads ck by a quarter period so each write word is centred on its edge
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      phase_reg <= PH_A;
      ck_reg    <= 1'b0;
      dk_reg    <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_reg + 1'b1;
      ck_reg    <= phase_reg == PH_B || phase_reg == PH_C;
      dk_reg    <= phase_reg == PH_A || phase_reg == PH_B;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      state_reg <= ST_IDLE;
    else if (boundary)
    begin
      case (state_reg)
        ST_IDLE:
          if (req_valid)
            state_reg <= ST_CMD;
        ST_CMD:
          state_reg <= is_wr_reg ? ST_WDATA : ST_IDLE;
        ST_WDATA:
          if (words_left_reg == '0)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // a command stands for exactly one ck period, then the port deselects
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sel_n_reg    <= 1'b1;
      cmd_pins_reg <= PINS_NOP;
      addr_reg     <= '0;
      bank_reg     <= '0;
      is_wr_reg    <= 1'b0;
      blc_reg      <= BLC_RST;
    end
    else if (take)
    begin
      sel_n_reg    <= 1'b0;
      cmd_pins_reg <= sdpp_encode(req_cmd);
      addr_reg     <= req_addr;
      bank_reg     <= req_bank;
      is_wr_reg    <= req_cmd == CMD_WRITE;
      if (req_cmd == CMD_CFG)
        blc_reg <= req_addr[BLC_LSB +: BLC_W];
    end
    else if (boundary)
    begin
      sel_n_reg    <= 1'b1;
      cmd_pins_reg <= PINS_NOP;
    end
  end

  // idle words go out masked so stray dk edges never store anything
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wbuf_reg       <= '0;
      mbuf_reg       <= '1;
      wdata_reg      <= '0;
      wmask_reg      <= 1'b1;
      words_left_reg <= '0;
    end
    else if (take)
    begin
      wbuf_reg <= req_wdata;
      mbuf_reg <= req_wmask;
    end
    else if (launch)
    begin
      wdata_reg <= wbuf_reg[DATA_W-1:0];
      wmask_reg <= mbuf_reg[0];
      wbuf_reg  <= wbuf_reg >> DATA_W;
      mbuf_reg  <= mbuf_reg >> 1;
      if (state_reg == ST_CMD)
        words_left_reg <= (sdpp_pairs(blc_reg) << 1) - 1'b1;
      else
        words_left_reg <= words_left_reg - 1'b1;
    end
    else if (boundary)
    begin
      wdata_reg <= '0;
      wmask_reg <= 1'b1;
    end
  end

  // read words change on ck edges made here, so they are sampled mid-eye
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rd_low_reg <= '0;
      rd_vld_reg <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data   <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (phase_reg == PH_C)
      begin
        rd_low_reg <= pins.read_data_bus;
        rd_vld_reg <= pins.read_valid;
      end
      if (phase_reg == PH_A && rd_vld_reg)
      begin
        rsp_valid <= 1'b1;
        rsp_data  <= {pins.read_data_bus, rd_low_reg};
      end
    end
  end

  assign pins.main_clk_true  = ck_reg;
  assign pins.main_clk_comp  = !ck_reg;
  assign pins.wr_strobe_true = dk_reg;
  assign pins.wr_strobe_comp = !dk_reg;
  assign pins.sel_n          = sel_n_reg;
  assign pins.wr_cmd_n       = cmd_pins_reg[1];
  assign pins.ref_cmd_n      = cmd_pins_reg[0];
  assign pins.addr_bus       = addr_reg;
  assign pins.bank_sel       = bank_reg;
  assign pins.write_data_bus = wdata_reg;
  assign pins.write_mask     = wmask_reg;

endmodule

/* hw/sdpp_dev.sv */
// device end of the dram pin port: decode, burst storage, ddr read-out
`timescale 1ns/1ps
module sdpp_dev #(
  parameter int COL_W  = sdpp_pkg::COL_W_DEF,
  parameter int RD_LAT = sdpp_pkg::RD_LAT_DEF
) (
  sdpp_if.dev                              pins,
  input  wire logic                        rst_n,
  output logic [sdpp_pkg::BLC_W-1:0]       burst_words,
  output logic                             burst_busy,
  output logic [sdpp_pkg::REF_CNT_W-1:0]   refresh_count
);
  import sdpp_pkg::*;

  localparam int IDX_W = BANK_W + COL_W;

  logic                 lclk;
  logic                 rst_meta_reg;
  logic                 rst_sync_reg;
  logic                 cmd_take;
  sdpp_cmd_e            cmd;
  logic                 take_read;
  logic                 take_write;
  logic                 take_cfg;
  logic                 take_ref;
  logic [2*DATA_W-1:0]  mem [2**IDX_W];
  logic [BLC_W-1:0]     blc_reg;
  logic [REF_CNT_W-1:0] ref_cnt_reg;
  logic                 wr_start_reg;
  logic [CNT_W-1:0]     wr_left_reg;
  logic [BANK_W-1:0]    wr_bank_reg;
  logic [COL_W-1:0]     wr_col_reg;
  logic [IDX_W-1:0]     wr_idx;
  logic [CNT_W-1:0]     rd_wait_reg;
  logic [CNT_W-1:0]     rd_left_reg;
  logic [BANK_W-1:0]    rd_bank_reg;
  logic [COL_W-1:0]     rd_col_reg;
  logic                 rd_fire;
  logic [DATA_W-1:0]    d_first_reg;
  logic                 m_first_reg;
  logic [DATA_W-1:0]    q_first_reg;
  logic [DATA_W-1:0]    q_second_reg;
  logic                 q_valid_reg;

  assign lclk = pins.main_clk_true;

  // reset arrives from the system side and is retimed onto ck
  always_ff @(posedge lclk)
  begin
    rst_meta_reg <= rst_n;
    rst_sync_reg <= rst_meta_reg;
  end

  assign cmd_take = rst_sync_reg && !pins.sel_n;
  assign cmd      = sdpp_decode({pins.wr_cmd_n, pins.ref_cmd_n});

  // one shared decode, so every block agrees on what was accepted
  assign take_read  = cmd_take && cmd == CMD_READ;
  assign take_write = cmd_take && cmd == CMD_WRITE;
  assign take_cfg   = cmd_take && cmd == CMD_CFG;
  assign take_ref   = cmd_take && cmd == CMD_REF;

  always_ff @(posedge lclk)
  begin
    if (!rst_sync_reg)
      blc_reg <= BLC_RST;
    else if (take_cfg)
      blc_reg <= pins.addr_bus[BLC_LSB +: BLC_W];
  end

  // refresh row comes from inside, so only the count is kept here
  always_ff @(posedge lclk)
  begin
    if (!rst_sync_reg)
      ref_cnt_reg <= '0;
    else if (take_ref)
      ref_cnt_reg <= ref_cnt_reg + 1'b1;
  end

  // write data trails its command by one ck period
  always_ff @(posedge lclk)
  begin
    if (!rst_sync_reg)
    begin
      wr_start_reg <= 1'b0;
      wr_left_reg  <= '0;
    end
    else
    begin
      wr_start_reg <= take_write;
      if (wr_start_reg)
        wr_left_reg <= sdpp_pairs(blc_reg);
      else if (wr_left_reg != '0)
        wr_left_reg <= wr_left_reg - 1'b1;
    end
  end

  always_ff @(posedge lclk)
  begin
    if (take_write)
    begin
      wr_bank_reg <= pins.bank_sel;
      wr_col_reg  <= pins.addr_bus[COL_W-1:0];
    end
    else if (wr_left_reg != '0)
      wr_col_reg <= wr_col_reg + 1'b1;
  end

  assign wr_idx = {wr_bank_reg, wr_col_reg};

  // dk is launched a quarter period ahead of ck by the controller, so the
  // burst counters are settled at every dk edge; a fixed-phase path
  always_ff @(posedge pins.wr_strobe_true)
  begin
    d_first_reg <= pins.write_data_bus;
    m_first_reg <= pins.write_mask;
  end

  always_ff @(posedge pins.wr_strobe_comp)
  begin
    if (wr_left_reg != '0)
    begin
      if (!m_first_reg)
        mem[wr_idx][DATA_W-1:0] <= d_first_reg;
      if (!pins.write_mask)
        mem[wr_idx][2*DATA_W-1:DATA_W] <= pins.write_data_bus;
    end
  end

  assign rd_fire = rd_wait_reg == '0 && rd_left_reg != '0;

  // a new read replaces one still counting; the controller does not hold back a read for that
  always_ff @(posedge lclk)
  begin
    if (!rst_sync_reg)
    begin
      rd_wait_reg <= '0;
      rd_left_reg <= '0;
    end
    else if (take_read)
    begin
      rd_wait_reg <= CNT_W'(RD_LAT);
      rd_left_reg <= sdpp_pairs(blc_reg);
    end
    else if (rd_wait_reg != '0)
      rd_wait_reg <= rd_wait_reg - 1'b1;
    else if (rd_left_reg != '0)
      rd_left_reg <= rd_left_reg - 1'b1;
  end

  always_ff @(posedge lclk)
  begin
    if (take_read)
    begin
      rd_bank_reg <= pins.bank_sel;
      rd_col_reg  <= pins.addr_bus[COL_W-1:0];
    end
    else if (rd_fire)
      rd_col_reg <= rd_col_reg + 1'b1;
  end

  always_ff @(posedge lclk)
  begin
    if (!rst_sync_reg || !rd_fire)
    begin
      q_valid_reg  <= 1'b0;
      q_first_reg  <= '0;
      q_second_reg <= '0;
    end
    else
    begin
      q_valid_reg                 <= 1'b1;
      {q_second_reg, q_first_reg} <= mem[{rd_bank_reg, rd_col_reg}];
    end
  end

  // first word in the ck high half, second in the low half
  generate
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
      assign pins.read_data_bus[i*HALF_W +: HALF_W] = lclk
        ? q_first_reg[i*HALF_W +: HALF_W]
        : q_second_reg[i*HALF_W +: HALF_W];
      assign pins.rd_strobe_true[i] = lclk;
      assign pins.rd_strobe_comp[i] = pins.main_clk_comp;
    end
  endgenerate

  assign pins.read_valid = q_valid_reg;

  assign burst_words   = blc_reg;
  assign refresh_count = ref_cnt_reg;
  assign burst_busy    = wr_start_reg || wr_left_reg != '0
                      || rd_wait_reg != '0 || rd_left_reg != '0;

endmodule

/* verification/sdpp_asserts.sv */
// concurrent checks on the pin bundle between controller and device
`timescale 1ns/1ps
module sdpp_asserts (
  input wire logic                       clock,
  input wire logic                       rst_n,
  input wire logic                       dev_rst_n,
  input wire logic                       main_clk_true,
  input wire logic                       main_clk_comp,
  input wire logic                       sel_n,
  input wire logic                       wr_cmd_n,
  input wire logic                       ref_cmd_n,
  input wire logic                       wr_strobe_true,
  input wire logic                       wr_strobe_comp,
  input wire logic [sdpp_pkg::LANES-1:0] rd_strobe_true,
  input wire logic [sdpp_pkg::LANES-1:0] rd_strobe_comp,
  input wire logic                       read_valid
);
  import sdpp_pkg::*;
  // ck is made from clock, so one sampling domain sees the whole link
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n || !dev_rst_n);

  a_ck_divide: assert property (
    $rose(main_clk_true) |-> ##2 $fell(main_clk_true) ##2 $rose(main_clk_true))
    else $error("link clock period wrong");
  a_pairs_inverse: assert property (
    main_clk_comp == !main_clk_true && wr_strobe_comp == !wr_strobe_true)
    else $error("complement clock not inverse");
  a_dk_leads_ck: assert property (
    $rose(wr_strobe_true) |-> ##1 $rose(main_clk_true))
    else $error("write strobe not a quarter ahead");
  a_cmd_at_rise: assert property (
    $fell(sel_n) |-> ##2 $rose(main_clk_true))
    else $error("command not framed on ck rise");
  a_sel_one_period: assert property (
    $fell(sel_n) |-> !sel_n[*4] ##1 sel_n)
    else $error("select low not one ck period");
  a_strobe_runs: assert property (
    $rose(rd_strobe_true[0]) |-> ##2 $fell(rd_strobe_true[0]) ##2 $rose(rd_strobe_true[0]))
    else $error("read strobe stopped");
  a_lane_copy: assert property (
    rd_strobe_true == {LANES{main_clk_true}} && rd_strobe_comp == ~rd_strobe_true)
    else $error("strobe lanes disagree");
  a_valid_edges: assert property (
    $changed(read_valid) |-> $rose(rd_strobe_true[0]))
    else $error("read valid off strobe rise");
  a_valid_pair: assert property (
    $rose(read_valid) |-> read_valid[*4])
    else $error("read valid shorter than a pair");
  a_read_lat: assert property (
    $rose(main_clk_true) && !sel_n && wr_cmd_n && ref_cmd_n |-> ##12 read_valid)
    else $error("read data late or missing");

  c_read: cover property ($rose(read_valid));
  c_write: cover property ($fell(sel_n) && !wr_cmd_n && ref_cmd_n);
  c_cfg: cover property ($fell(sel_n) && !wr_cmd_n && !ref_cmd_n);
  c_ref: cover property ($fell(sel_n) && wr_cmd_n && !ref_cmd_n);
endmodule

/* verification/separate_io_dram_pin_port_tb.sv */
// self-checking bench: controller and device joined over the pin bundle
`timescale 1ns/1ps
module separate_io_dram_pin_port_tb;
  import sdpp_pkg::*;
  logic                clock = 1'h0;
  logic                rst_n = 1'h0;
  logic                dev_rst_n = 1'h0;
  logic                req_valid = 1'h0;
  logic                req_ready;
  sdpp_cmd_e           req_cmd = CMD_READ;
  logic [BANK_W-1:0]   req_bank = '0;
  logic [ADDR_W-1:0]   req_addr = '0;
  logic [WBUF_W-1:0]   req_wdata = '0;
  logic [MAX_BL-1:0]   req_wmask = '0;
  logic                rsp_valid;
  logic [2*DATA_W-1:0] rsp_data;
  logic [BLC_W-1:0]    burst_words;
  logic                burst_busy;
  logic [7:0]          refresh_count;
  logic [DATA_W-1:0]   mem [8][16][2];
  logic [35:0]         rq [$];
  logic [31:0]         seed = 32'h00012118;
  int                  mismatches = 0;
  int                  compares = 0;
  int                  refs = 0;

  always #10 clock = ~clock;

  sdpp_if link ();
  sdpp_ctl sdpp_ctl_inst (.pins(link), .clock, .rst_n, .req_valid, .req_ready, .req_cmd,
    .req_bank, .req_addr, .req_wdata, .req_wmask, .rsp_valid, .rsp_data);
  sdpp_dev sdpp_dev_inst (.pins(link), .rst_n(dev_rst_n), .burst_words, .burst_busy,
    .refresh_count);
  sdpp_asserts sdpp_asserts_inst (.clock, .rst_n, .dev_rst_n,
    .main_clk_true(link.main_clk_true), .main_clk_comp(link.main_clk_comp),
    .sel_n(link.sel_n), .wr_cmd_n(link.wr_cmd_n), .ref_cmd_n(link.ref_cmd_n),
    .wr_strobe_true(link.wr_strobe_true), .wr_strobe_comp(link.wr_strobe_comp),
    .rd_strobe_true(link.rd_strobe_true), .rd_strobe_comp(link.rd_strobe_comp),
    .read_valid(link.read_valid));

  always @(negedge clock) if (rsp_valid === 1'h1) rq.push_back(rsp_data);

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // reserved code 3 runs as the shortest burst
  function automatic int pairs_for(input int code);
    return (code == 1) ? 2 : (code == 2) ? 4 : 1;
  endfunction

  function automatic logic [35:0] pair_of(input int b, input int c);
    return {mem[b][c%16][1], mem[b][c%16][0]};
  endfunction

  task automatic fail(input string s);
    mismatches++;
    $display("mismatch at %0t: %s", $time, s);
  endtask

  task automatic check_pair(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) fail("read pair differs");
  endtask

  task automatic check_val(input logic [7:0] got, input int exp);
    compares++;
    if (got !== exp[7:0]) fail("status value differs");
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ready is combinational, so it is judged at the falling edge before the take
  task automatic issue(input sdpp_cmd_e c, input int b, input int a);
    int n;
    n = 0;
    while (req_ready !== 1'h1 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 200) fail("request never taken");
    req_cmd = c;
    req_bank = b[BANK_W-1:0];
    req_addr = a[ADDR_W-1:0];
    req_valid = 1'h1;
    @(negedge clock);
    req_valid = 1'h0;
  endtask

  task automatic wr(input int b, input int col, input int p, input logic [7:0] m);
    logic [31:0] r;
    for (int k = 0; k < 8; k++)
    begin
      r = rnd();
      req_wdata[k*DATA_W+:DATA_W] = r[DATA_W-1:0];
      if (k < 2 * p && !m[k]) mem[b][(col+k/2)%16][k%2] = r[DATA_W-1:0];
    end
    req_wmask = m;
    issue(CMD_WRITE, b, (rnd() & 32'h000FFFF0) | col);
  endtask

  // pairs never written stay unknown in the model and are skipped
  task automatic rd(input int b, input int col, input int p);
    int n;
    n = 0;
    rq.delete();
    issue(CMD_READ, b, (rnd() & 32'h000FFFF0) | col);
    repeat (4) @(negedge clock);
    check_val({7'h00, burst_busy}, 1);
    while (rq.size() < p && n < 400)
    begin
      @(negedge clock);
      n++;
    end
    repeat (8) @(negedge clock);
    check_val({7'h00, burst_busy}, 0);
    check_val(8'(rq.size()), p);
    for (int j = 0; j < p; j++)
      if (^pair_of(b, col + j) !== 1'hx) check_pair(rq[j], pair_of(b, col + j));
  endtask

  initial
  begin
    logic [31:0] r;
    int          b;
    int          col;
    int          p;
    int          code;
    int          nref;
    repeat (5) @(negedge clock);
    rst_n = 1'h1;
    // device reset is retimed on ck, so ck must run while it is held
    repeat (20) @(negedge clock);
    dev_rst_n = 1'h1;
    repeat (16) @(negedge clock);
    for (int t = 0; t < 16; t++)
    begin
      r = rnd();
      code = (t < 4) ? t : r % 3;
      b = r[6:4];
      col = r[11:8];
      nref = r[13:12];
      p = pairs_for(code);
      issue(CMD_CFG, 0, (r & 32'h000FFFFC) | code);
      for (int i = 0; i < nref; i++)
        issue(CMD_REF, b, 0);
      wr(b, col, p, 8'h00);
      wr(b, col, p, r[23:16]);
      rd(b, col, p);
      rd(b ^ 4, col, p);
      check_val({6'h00, burst_words}, code);
      refs += nref;
      check_val(refresh_count, refs);
      $display("test %0d done", t);
    end
    stop_test();
  end

  initial
  begin
    #400000;
    fail("watchdog expired");
    stop_test();
  end
endmodule
